// ===== dv/ecp_pe_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// Processing element model
// ----------------------------------------
module ecp_elem_model
	import ecp_pkg::*;
(
	// Clock
	input wire logic mclk,
	// Requests and events
	output logic req_valid,
	output ecp_req_t req,
	output ecp_det_t det,
	output ecp_elem_obs_t elem_obs,
	// Response
	input wire logic rsp_valid,
	input wire ecp_rsp_t rsp
);
	initial begin
		req_valid = 1'b0;
		req = '0;
		det = '0;
		elem_obs = '0;
	end

	// The released request shows its inverse and det clears, so a stale value is never mistaken for a live one.
	task automatic access(input ecp_req_t r, input ecp_det_t d, output ecp_rsp_t got);
		@(posedge mclk);
		#1;
		req_valid = 1'b1;
		req = r;
		det = d;
		@(posedge mclk);
		#1;
		req_valid = 1'b0;
		req = ~r;
		det = '0;
		got = rsp_valid ? rsp : ~rsp;
	endtask

	task automatic pulse(input ecp_elem_obs_t o);
		@(posedge mclk);
		#1;
		elem_obs = o;
		@(posedge mclk);
		#1;
		elem_obs = '0;
	endtask
endmodule // ecp_elem_model

// ===== dv/ecp_props.sv
`timescale 1ns/1ps

// ----------------------------------------
// Response and containment checks
// ----------------------------------------
module ecp_props
	import ecp_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Access side
	input wire logic req_valid,
	input wire ecp_det_t det,
	input wire logic inband_impl,
	input wire logic inband_en,
	input wire logic rsp_valid,
	input wire ecp_rsp_t rsp,
	input wire logic log_valid,
	// Processing element observation
	input wire ecp_elem_obs_t elem_obs,
	input wire logic consumed,
	input wire logic propagated,
	input wire logic silent_prop
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence s_err;
		req_valid && det.detect;
	endsequence
	sequence s_unfixed;
		s_err ##0 !det.correctable;
	endsequence

	a_rsp_beat: assert property (req_valid |=> rsp_valid) else $error("missing beat");
	a_rsp_quiet: assert property (!req_valid |=> !rsp_valid) else $error("stray beat");
	a_fix_first: assert property (s_err ##0 det.correctable |=> rsp.status == ECP_ST_CORRECTED)
		else $error("correctable not corrected");
	a_defer_next: assert property (s_unfixed ##0 det.deferrable |=> rsp.status == ECP_ST_POISONED)
		else $error("deferrable not poisoned");
	a_inband_last: assert property (s_unfixed ##0 (!det.deferrable && inband_impl && inband_en)
		|=> rsp.status == ECP_ST_ERROR) else $error("no in-band error");
	a_log_err: assert property (s_err |=> log_valid) else $error("error not logged");
	a_consume_next: assert property ((elem_obs.commit_corrupt || elem_obs.fetch_commit_corrupt
		|| elem_obs.walk_commit_corrupt) |=> consumed) else $error("consumption missed");
	a_prop_next: assert property ((elem_obs.spurious_signal || elem_obs.imprecise_exc
		|| elem_obs.modified_discard) |=> propagated) else $error("propagation missed");
	a_silent_hold: assert property (silent_prop |=> silent_prop) else $error("silent flag lost");
endmodule // ecp_props

// ===== dv/tb.sv
`timescale 1ns/1ps

module tb;
	import ecp_pkg::*;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic req_valid, req_ready, inband_impl, inband_en, rsp_valid, log_valid;
	logic fault_irq, recovery_irq, critical_irq, consumed, reg_tainted, propagated, silent_prop;
	ecp_req_t req;
	ecp_det_t det;
	ecp_irq_cfg_t irq_cfg;
	ecp_rsp_t rsp;
	ecp_log_t log_rec;
	ecp_elem_obs_t elem_obs;
	logic [15:0] err_count;
	logic [31:0] seed = 32'h2cc6_0f8b;
	logic [31:0] mem [256];
	logic pois [256];
	logic rt = 1'b0;
	int cnt = 0;
	int mismatches = 0;
	int total_checks = 0;

	always #10 mclk = ~mclk;

	ecp_top uut (.mclk(mclk), .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready),
		.req(req), .det(det), .inband_impl(inband_impl), .inband_en(inband_en),
		.irq_cfg(irq_cfg), .rsp_valid(rsp_valid), .rsp(rsp), .log_valid(log_valid),
		.log_rec(log_rec), .err_count(err_count), .fault_irq(fault_irq),
		.recovery_irq(recovery_irq), .critical_irq(critical_irq), .elem_obs(elem_obs),
		.consumed(consumed), .reg_tainted(reg_tainted), .propagated(propagated),
		.silent_prop(silent_prop));
	ecp_elem_model elem (.mclk(mclk), .req_valid(req_valid), .req(req), .det(det),
		.elem_obs(elem_obs), .rsp_valid(rsp_valid), .rsp(rsp));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask

	// Flags f are poison, tainted source, detect, correctable, deferrable.
	task automatic acc(input ecp_kind_t k, input int a, input logic [31:0] wd, input logic [4:0] f);
		ecp_rsp_t got;
		logic [1:0] es;
		logic [31:0] ed;
		logic pm, ib, unc;
		pm = f[4] | (f[3] & rt);
		ib = inband_impl & inband_en;
		unc = f[2] & !f[1] & !f[0] & !ib;
		es = f[1] ? 2'd1 : f[0] ? 2'd2 : ib ? 2'd3 : 2'd0;
		if (!f[2]) es = (k[1] ? pm : pois[a]) ? 2'd2 : 2'd0;
		ed = (k == ECP_KIND_READ && es != 2'd3) ? mem[a] : 32'h0000_0000;
		if (k[1] && es != 2'd3) begin
			mem[a] = wd;
			pois[a] = (f[2] & !f[1]) | pm;
		end else if (f[2] & !f[1] & f[0]) begin
			pois[a] = 1'b1;
		end
		if (f[2]) cnt++;
		elem.access(ecp_req_t'{k, 8'(a), wd, f[4], f[3]}, ecp_det_t'(f[2:0]), got);
		chk("rsp", {es, ed}, got);
		chk("irq", {f[2], f[2] & irq_cfg.fault_en, f[2] & !f[1] & irq_cfg.recovery_en,
			unc & irq_cfg.critical_en}, {log_valid, fault_irq, recovery_irq, critical_irq});
		if (f[2]) chk("log", {k, es, 8'(a)}, log_rec);
		chk("count", 16'(cnt), err_count);
	endtask

	task automatic ev(input logic [10:0] o, input logic [2:0] e);
		elem.pulse(ecp_elem_obs_t'(o));
		if (|o[10:8]) rt = 1'b1;
		else if (o[7] | o[6]) rt = 1'b0;
		chk("obs", {e, rt}, {consumed, propagated, silent_prop, reg_tainted});
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		inband_impl = 1'b1;
		inband_en = 1'b1;
		irq_cfg = 3'b111;
		repeat (10) @(posedge mclk);
		#1;
		rstn = 1'b1;
		chk("ready", 1'b1, req_ready);
		for (int i = 0; i < 8; i++) acc(ECP_KIND_WRITE, i, xs(), 5'h00);
		for (int i = 0; i < 8; i++) acc(ECP_KIND_READ, i, 0, 5'h00);
		$display("test plain access done");
		for (int k = 0; k < 4; k++) begin
			for (int j = 0; j < 4; j++) begin
				inband_impl = (j != 3) || k[0];
				inband_en = (j != 3) || !k[0];
				irq_cfg = 3'(xs());
				acc(ecp_kind_t'(k), j, xs(), j == 0 ? 5'h07 : j == 1 ? 5'h05 : 5'h04);
			end
		end
		inband_en = 1'b1;
		inband_impl = 1'b1;
		irq_cfg = 3'b111;
		for (int i = 0; i < 8; i++) acc(ECP_KIND_READ, i, 0, 5'h00);
		for (int i = 0; i < 4; i++) acc(ECP_KIND_WRITE_FULL, i, xs(), 5'h00);
		for (int i = 0; i < 4; i++) acc(ECP_KIND_READ, i, 0, 5'h00);
		$display("test error responses done");
		ev(11'h400, 3'b100);
		acc(ECP_KIND_WRITE, 9, xs(), 5'h08);
		ev(11'h040, 3'b000);
		acc(ECP_KIND_WRITE, 9, xs(), 5'h08);
		ev(11'h030, 3'b000);
		// A fetch consumption beside a barrier in one cycle must leave the taint set.
		ev(11'h240, 3'b100);
		acc(ECP_KIND_WRITE, 9, xs(), 5'h08);
		for (int b = 10; b >= 0; b--) ev(11'h001 << b, {b >= 8, b <= 2 || b == 5, b <= 5});
		$display("test containment done");
		rstn = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		rstn = 1'b1;
		cnt = 0;
		rt = 1'b0;
		chk("reset", {err_count, silent_prop, reg_tainted, rsp_valid, log_valid}, 20'h0_0000);
		acc(ECP_KIND_READ, 0, 0, 5'h04);
		$display("test reset done");
		tally_and_finish();
	end

	// About fifty accesses and fifteen pulses of two cycles each; the limit is over fifteen times that.
	initial begin
		#50_000;
		mismatches++;
		tally_and_finish();
	end
endmodule // tb

bind ecp_top ecp_props chk_i (.mclk(mclk), .rstn(rstn), .req_valid(req_valid), .det(det),
	.inband_impl(inband_impl), .inband_en(inband_en), .rsp_valid(rsp_valid), .rsp(rsp),
	.log_valid(log_valid), .elem_obs(elem_obs), .consumed(consumed), .propagated(propagated),
	.silent_prop(silent_prop));

// ===== rtl/ecp_granule_store.sv
`timescale 1ns/1ps

// Each word is one protection granule with its own poison mark.
module ecp_granule_store
	import ecp_pkg::*;
#(
	parameter int unsigned DATA_W = ECP_DATA_W,
	parameter int unsigned ADDR_W = ECP_ADDR_W,
	parameter int unsigned DEPTH = ECP_DEPTH
) (
	// Clock
	input wire logic mclk,
	// Write port
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic wr_poison,
	// Poison-only update
	input wire logic mark_en,
	// Read port
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [DATA_W-1:0] rd_data,
	output logic rd_poison
);

	logic [DATA_W-1:0] mem_q [DEPTH];
	logic [DEPTH-1:0] poison_q;

	// Poison marks are plain flops so that they are clean from power-up
	// only after the first write; memory content itself is not reset.
	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
			poison_q[wr_addr] <= wr_poison;
		end else if (mark_en) begin
			poison_q[wr_addr] <= 1'b1;
		end
	end

	assign rd_data = mem_q[rd_addr];
	assign rd_poison = poison_q[rd_addr];

endmodule // ecp_granule_store

// ===== rtl/ecp_pkg.sv
package ecp_pkg;

	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int unsigned ECP_DATA_W = 32;
	localparam int unsigned ECP_ADDR_W = 8;
	localparam int unsigned ECP_DEPTH = 256;

	// ---------------------------------------------------------------
	// Reset values and counter constants
	// ---------------------------------------------------------------
	localparam logic [ECP_DATA_W-1:0] ECP_DATA_RST = 32'h0000_0000;
	localparam logic [ECP_ADDR_W-1:0] ECP_ADDR_RST = 8'h00;
	localparam logic [15:0] ECP_CNT_RST = 16'h0000;
	localparam logic [15:0] ECP_CNT_ONE = 16'h0001;
	localparam logic [15:0] ECP_CNT_MAX = 16'hffff;

	// ---------------------------------------------------------------
	// Encodings
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		ECP_KIND_READ = 2'b00,
		ECP_KIND_CMO = 2'b01,
		ECP_KIND_WRITE = 2'b10,
		ECP_KIND_WRITE_FULL = 2'b11
	} ecp_kind_t;

	typedef enum logic [1:0] {
		ECP_ST_NORMAL = 2'b00,
		ECP_ST_CORRECTED = 2'b01,
		ECP_ST_POISONED = 2'b10,
		ECP_ST_ERROR = 2'b11
	} ecp_status_t;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		ecp_kind_t kind;
		logic [ECP_ADDR_W-1:0] addr;
		logic [ECP_DATA_W-1:0] wdata;
		logic poison;
		logic src_tainted;
	} ecp_req_t;

	typedef struct packed {
		logic detect;
		logic correctable;
		logic deferrable;
	} ecp_det_t;

	typedef struct packed {
		ecp_status_t status;
		logic [ECP_DATA_W-1:0] data;
	} ecp_rsp_t;

	typedef struct packed {
		ecp_kind_t kind;
		ecp_status_t status;
		logic [ECP_ADDR_W-1:0] addr;
	} ecp_log_t;

	typedef struct packed {
		logic fault_en;
		logic recovery_en;
		logic critical_en;
	} ecp_irq_cfg_t;

	typedef struct packed {
		logic commit_corrupt;
		logic fetch_commit_corrupt;
		logic walk_commit_corrupt;
		logic err_exc_taken;
		logic sync_barrier;
		logic other_state_corrupt;
		logic other_state_signalled;
		logic required_op;
		logic spurious_signal;
		logic imprecise_exc;
		logic modified_discard;
	} ecp_elem_obs_t;

endpackage

// ===== rtl/ecp_top.sv
`timescale 1ns/1ps

// Functional notes
// - Read or maintenance error: correct, else poison, else in-band error if enabled.
// - Write error: correct, else poison the written location, else in-band error if enabled, else poison it uncontained.
// - Each detected error may be logged and raise fault or recovery interrupts.
// - Recording node stores the error and raises interrupts as configured.
// - Atomic write of a whole granule resets it and replaces its old poison with the write's own.
// - Committing a corrupt value into architectural state consumes the error.
// - A corrupt fetch is consumed only when its instruction commits.
// - A corrupt walk is consumed when it serves a committed access.
// - Before exception or barrier, corrupt registers leave only as signalled poison.
// - Corrupt value outside registers, unsignalled and not required, is silent propagation.
// - After exception or barrier, storing a corrupt register is not silent.
// - Fault-caused spurious signal assertion counts as propagation.
// - Fault-caused imprecise exception other than the error exception counts as propagation.
// - Fault-caused discard of modified data counts as propagation.
module ecp_top
	import ecp_pkg::*;
#(
	parameter int unsigned DATA_W = ECP_DATA_W,
	parameter int unsigned ADDR_W = ECP_ADDR_W,
	parameter int unsigned DEPTH = ECP_DEPTH
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Access request from the processing element
	input wire logic req_valid,
	output logic req_ready,
	input wire ecp_req_t req,
	// Error detector result for the access in the same cycle
	input wire ecp_det_t det,
	// Static configuration
	input wire logic inband_impl,
	input wire logic inband_en,
	input wire ecp_irq_cfg_t irq_cfg,
	// Access response
	output logic rsp_valid,
	output ecp_rsp_t rsp,
	// Error record
	output logic log_valid,
	output ecp_log_t log_rec,
	output logic [15:0] err_count,
	// Interrupts of the recording node
	output logic fault_irq,
	output logic recovery_irq,
	output logic critical_irq,
	// Processing element observation
	input wire ecp_elem_obs_t elem_obs,
	output logic consumed,
	output logic reg_tainted,
	output logic propagated,
	output logic silent_prop
);

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	logic st_wr_en;
	logic st_mark_en;
	logic st_wr_poison;
	logic [DATA_W-1:0] st_rd_data;
	logic st_rd_poison;

	ecp_granule_store #(
		.DATA_W(DATA_W),
		.ADDR_W(ADDR_W),
		.DEPTH(DEPTH)
	) u_store (
		.mclk(mclk),
		.wr_en(st_wr_en),
		.wr_addr(req.addr),
		.wr_data(req.wdata),
		.wr_poison(st_wr_poison),
		.mark_en(st_mark_en),
		.rd_addr(req.addr),
		.rd_data(st_rd_data),
		.rd_poison(st_rd_poison)
	);

	// ---------------------------------------------------------------
	// Access decision
	// ---------------------------------------------------------------
	logic rsp_valid_q, rsp_valid_d;
	ecp_rsp_t rsp_q, rsp_d;
	logic log_valid_q, log_valid_d;
	ecp_log_t log_q, log_d;
	logic [15:0] cnt_q, cnt_d;
	logic fault_q, fault_d;
	logic recov_q, recov_d;
	logic crit_q, crit_d;
	logic taint_q, taint_d;

	logic take;
	logic is_write;
	logic inband_ok;
	logic err;
	logic uncontained;

	// The block answers every access in the following cycle, so it never stalls.
	assign req_ready = 1'b1;
	assign take = req_valid & req_ready;
	assign is_write = (req.kind == ECP_KIND_WRITE) || (req.kind == ECP_KIND_WRITE_FULL);
	assign inband_ok = inband_impl & inband_en;
	assign err = take & det.detect;

	always_comb begin
		st_wr_en = 1'b0;
		st_mark_en = 1'b0;
		st_wr_poison = 1'b0;
		rsp_d = '{status: ECP_ST_NORMAL, data: st_rd_data};
		uncontained = 1'b0;
		if (take && is_write) begin
			st_wr_en = 1'b1;
			// Tainted register data may leave only as poison until the sync point.
			st_wr_poison = req.poison | (req.src_tainted & taint_q);
			rsp_d.data = ECP_DATA_RST;
			if (det.detect) begin
				if (det.correctable) begin
					rsp_d.status = ECP_ST_CORRECTED;
				end else if (det.deferrable) begin
					st_wr_poison = 1'b1;
					rsp_d.status = ECP_ST_POISONED;
				end else if (inband_ok) begin
					st_wr_en = 1'b0;
					rsp_d.status = ECP_ST_ERROR;
				end else begin
					st_wr_poison = 1'b1;
					uncontained = 1'b1;
				end
			end else if (st_wr_poison) begin
				rsp_d.status = ECP_ST_POISONED;
			end
			// A full atomic write wipes any old mark; only fresh poison survives.
			if (req.kind == ECP_KIND_WRITE_FULL && !det.detect) begin
				st_wr_poison = req.poison | (req.src_tainted & taint_q);
				rsp_d.status = st_wr_poison ? ECP_ST_POISONED : ECP_ST_NORMAL;
			end
		end else if (take) begin
			if (req.kind == ECP_KIND_CMO) begin
				rsp_d.data = ECP_DATA_RST;
			end
			if (det.detect) begin
				if (det.correctable) begin
					rsp_d.status = ECP_ST_CORRECTED;
				end else if (det.deferrable) begin
					st_mark_en = 1'b1;
					rsp_d.status = ECP_ST_POISONED;
				end else if (inband_ok) begin
					rsp_d.status = ECP_ST_ERROR;
					rsp_d.data = ECP_DATA_RST;
				end else begin
					uncontained = 1'b1;
				end
			end else if (st_rd_poison) begin
				// Deferred earlier: the poison travels on with the data.
				rsp_d.status = ECP_ST_POISONED;
			end
		end
		rsp_valid_d = take;
	end

	// ---------------------------------------------------------------
	// Error record and interrupts
	// ---------------------------------------------------------------
	always_comb begin
		log_valid_d = err;
		log_d = log_q;
		cnt_d = cnt_q;
		fault_d = 1'b0;
		recov_d = 1'b0;
		crit_d = 1'b0;
		if (err) begin
			log_d = '{kind: req.kind, status: rsp_d.status, addr: req.addr};
			if (cnt_q != ECP_CNT_MAX) begin
				cnt_d = 16'(cnt_q + ECP_CNT_ONE);
			end
			fault_d = irq_cfg.fault_en;
			recov_d = irq_cfg.recovery_en & ~det.correctable;
			// Nothing contained the error, so it is escalated as critical.
			crit_d = irq_cfg.critical_en & uncontained;
		end
	end

	// ---------------------------------------------------------------
	// Consumption and containment
	// ---------------------------------------------------------------
	logic consumed_q, consumed_d;
	logic prop_q, prop_d;
	logic silent_q, silent_d;
	logic consume_now;
	logic other_silent;

	// Speculative fetches and walks do not count until their user commits.
	assign consume_now = elem_obs.commit_corrupt
		| elem_obs.fetch_commit_corrupt
		| elem_obs.walk_commit_corrupt;
	assign other_silent = elem_obs.other_state_corrupt & ~elem_obs.other_state_signalled
		& ~elem_obs.required_op;

	always_comb begin
		consumed_d = consume_now;
		taint_d = taint_q;
		// A new consumption in the same cycle as a sync point keeps the taint.
		if (elem_obs.err_exc_taken || elem_obs.sync_barrier) begin
			taint_d = 1'b0;
		end
		if (consume_now) begin
			taint_d = 1'b1;
		end
		prop_d = elem_obs.spurious_signal
			| elem_obs.imprecise_exc
			| elem_obs.modified_discard
			| other_silent;
		silent_d = silent_q | other_silent;
	end

	// ---------------------------------------------------------------
	// State registers
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rsp_valid_q <= 1'b0;
			rsp_q <= '{status: ECP_ST_NORMAL, data: ECP_DATA_RST};
			log_valid_q <= 1'b0;
			log_q <= '{kind: ECP_KIND_READ, status: ECP_ST_NORMAL, addr: ECP_ADDR_RST};
			cnt_q <= ECP_CNT_RST;
			fault_q <= 1'b0;
			recov_q <= 1'b0;
			crit_q <= 1'b0;
			taint_q <= 1'b0;
			consumed_q <= 1'b0;
			prop_q <= 1'b0;
			silent_q <= 1'b0;
		end else begin
			rsp_valid_q <= rsp_valid_d;
			rsp_q <= rsp_d;
			log_valid_q <= log_valid_d;
			log_q <= log_d;
			cnt_q <= cnt_d;
			fault_q <= fault_d;
			recov_q <= recov_d;
			crit_q <= crit_d;
			taint_q <= taint_d;
			consumed_q <= consumed_d;
			prop_q <= prop_d;
			silent_q <= silent_d;
		end
	end

	assign rsp_valid = rsp_valid_q;
	assign rsp = rsp_q;
	assign log_valid = log_valid_q;
	assign log_rec = log_q;
	assign err_count = cnt_q;
	assign fault_irq = fault_q;
	assign recovery_irq = recov_q;
	assign critical_irq = crit_q;
	assign consumed = consumed_q;
	assign reg_tainted = taint_q;
	assign propagated = prop_q;
	assign silent_prop = silent_q;

endmodule // ecp_top
